//--- core/cst_pkg.sv
/*
 call supervision timers: shared constants, field layouts and state codes.
 assumes a 100 mhz system clock and classic wishbone register access.
 */
// Functional notes
// - abort call when no tone before wait limit
// - accept 2100 or 2225 hz answer tone, 40 tolerance
// - recognise ring square wave 15.3 to 68 hz
// - block data 2 s data, 4 s fax answer
// - enter data mode only after link and handshake
// - throttle terminal via xoff/xon or rts/cts
// - +++ returns to command; off above 127
// - v.22bis and below drop on carrier loss
// - retrain until good, drop after 30 s
// - idle limit 0..255 s, zero disables
// - terminal or line data restarts idle timer
// - v.32+ without ec ends call on cleardown
// - detect break both sides, act per setting
// - rate shift within modulation when enabled
// - rts flow control only when enabled, normal/ec
// - upstream cap 48k pcm, 32.2k otherwise, pcm off
// - v.92 features only with v.92 supporting server
package cst_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
    localparam logic [7:0] BILL_DATA_S = 8'h02;
    localparam logic [7:0] BILL_FAX_S = 8'h04;
    localparam logic [7:0] RETRAIN_S = 8'h1e;
    // ring period bounds in cycles: 15.3 hz longest, 68 hz shortest
    localparam int unsigned RING_MAX_CYC = CLK_HZ * 10 / 153;
    localparam int unsigned RING_MIN_CYC = CLK_HZ / 68;
    localparam logic [3:0] RING_EDGES = 4'h4;
    // ----------------------------------------
    // tones in hz
    // ----------------------------------------
    localparam logic [11:0] TONE_ITU_HZ = 12'd2100;
    localparam logic [11:0] TONE_BELL_HZ = 12'd2225;
    localparam logic [11:0] TONE_TOL_HZ = 12'd40;
    // ----------------------------------------
    // upstream caps in 100 bps units
    // ----------------------------------------
    localparam logic [9:0] UP_PCM_MAX = 10'd480;
    localparam logic [9:0] UP_STD_MAX = 10'd322;
    localparam logic [7:0] ESC_LIMIT = 8'h7f;
    localparam logic [7:0] ESC_PLUS = 8'h2b;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TIMES = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_IRQ = 8'h0c;
    localparam logic [7:0] A_MASK = 8'h10;
    localparam logic [7:0] A_RATE = 8'h14;
    // ctrl fields
    localparam int C_RETRAIN = 0;
    localparam int C_SHIFT = 1;
    localparam int C_RTS = 2;
    localparam int C_SWFC = 3;
    localparam int C_PCM = 4;
    localparam int C_HOLD = 5;
    localparam int C_QC = 6;
    localparam int C_FAX = 7;
    localparam int C_BELL = 8;
    localparam int C_BRK = 9;
    localparam int C_ESC = 16;
    localparam logic [31:0] CTRL_RST = 32'h002b_0000;
    // times: tone_wait_limit [7:0], carrier_loss_delay [15:8], idle [23:16]
    localparam logic [31:0] TIMES_RST = 32'h0000_0e32;
    // irq bits
    localparam int I_ABORT = 0;
    localparam int I_CARRIER = 1;
    localparam int I_RETRAIN = 2;
    localparam int I_IDLE = 3;
    localparam int I_CLEAR = 4;
    localparam int I_BREAK = 5;
    localparam int I_ESCAPE = 6;
    localparam int I_RING = 7;
    localparam int NIRQ = 8;
    // ----------------------------------------
    // call state
    // ----------------------------------------
    typedef enum logic [2:0] {
        CST_IDLE = 3'b000,
        CST_DIAL = 3'b001,
        CST_BILL = 3'b010,
        CST_HAND = 3'b011,
        CST_DATA = 3'b100,
        CST_RETR = 3'b101,
        CST_CMD = 3'b110
    } cst_state_t;
    // line modulation classes
    localparam logic [1:0] MOD_LOW = 2'h0;
    localparam logic [1:0] MOD_V32 = 2'h1;
    localparam logic [1:0] MOD_V90 = 2'h2;
    localparam logic [1:0] MOD_V92 = 2'h3;
endpackage

//--- core/cst_top.sv
/*
 call supervision timers: call state machine, timers, flow gating, register slave.
 assumes synchronous inputs from the line dsp and the serial port, 100 mhz clk_i.
 */
`timescale 1ns/100ps
module cst_top
    import cst_pkg::*;
#(
    parameter int unsigned TICK_LEN = cst_pkg::TICK_CYC
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic int_o,
    // call control
    input wire logic dial_done_i,
    input wire logic answer_i,
    input wire logic tone_valid_i,
    input wire logic [11:0] tone_hz_i,
    input wire logic ring_i,
    input wire logic handshake_done_i,
    input wire logic [1:0] mod_i,
    input wire logic ec_i,
    // line status
    input wire logic carrier_i,
    input wire logic quality_ok_i,
    input wire logic cleardown_i,
    input wire logic line_break_i,
    input wire logic line_data_i,
    input wire logic v92_server_i,
    input wire logic [2:0] srv_feat_i,
    input wire logic rate_up_i,
    input wire logic rate_dn_i,
    // terminal side
    input wire logic dte_valid_i,
    input wire logic [7:0] dte_char_i,
    input wire logic dte_break_i,
    input wire logic rts_i,
    input wire logic rate_slower_i,
    // outputs
    output logic off_hook_o,
    output logic data_mode_o,
    output logic data_block_o,
    output logic retrain_o,
    output logic cts_o,
    output logic xoff_req_o,
    output logic [1:0] rate_step_o,
    output logic [9:0] up_max_o,
    output logic [2:0] feat_en_o,
    output logic break_act_o
);
    import cst_pkg::*;

    // ----------------------------------------
    // registers and shared tick
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] times_q;
    logic [NIRQ-1:0] irq_q;
    logic [NIRQ-1:0] mask_q;
    logic [NIRQ-1:0] ev;
    logic [31:0] tick_cnt_q;
    logic tick;
    cst_state_t st_q;
    logic [7:0] sec_q;
    logic [7:0] cd_q;
    logic [7:0] idle_q;
    logic wr;
    logic [7:0] esc_char;

    assign wr = cyc_i && stb_i && we_i && !ack_o;
    assign esc_char = ctrl_q[C_ESC +: 8];

    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick || st_q == CST_IDLE || st_q == CST_HAND)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end
    assign tick = (tick_cnt_q == TICK_LEN - 1);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= CTRL_RST;
            times_q <= TIMES_RST;
            mask_q <= '0;
        end
        else if (wr)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (sel_i[b] && adr_i == A_CTRL)
                    ctrl_q[b*8 +: 8] <= dat_i[b*8 +: 8];
                if (sel_i[b] && adr_i == A_TIMES)
                    times_q[b*8 +: 8] <= dat_i[b*8 +: 8];
            end
            if (sel_i[0] && adr_i == A_MASK)
                mask_q <= dat_i[NIRQ-1:0];
        end
    end

    // sticky events: a new event wins over a write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < NIRQ; gi++)
        begin : g_irq
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    irq_q[gi] <= 1'b0;
                else if (ev[gi])
                    irq_q[gi] <= 1'b1;
                else if (wr && sel_i[0] && adr_i == A_IRQ && dat_i[gi])
                    irq_q[gi] <= 1'b0;
            end
        end
    endgenerate
    assign int_o = |(irq_q & ~mask_q);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0;
        else
            case (adr_i)
                A_CTRL: dat_o <= ctrl_q;
                A_TIMES: dat_o <= times_q;
                A_STATUS: dat_o <= {24'h0, idle_q[3:0], 1'b0, st_q};
                A_IRQ: dat_o <= {24'h0, irq_q};
                A_MASK: dat_o <= {24'h0, mask_q};
                A_RATE: dat_o <= {20'h0, rate_step_o, up_max_o};
                default: dat_o <= 32'h0;
            endcase
    end

    // ----------------------------------------
    // tone and ring qualification
    // ----------------------------------------
    logic [11:0] tone_ctr;
    logic tone_ok;
    logic [31:0] ring_per_q;
    logic [3:0] ring_edges_q;
    logic ring_d1_q;
    logic ring_ok;

    assign tone_ctr = ctrl_q[C_BELL] ? TONE_BELL_HZ : TONE_ITU_HZ;
    assign tone_ok = tone_valid_i && (tone_hz_i >= tone_ctr - TONE_TOL_HZ)
        && (tone_hz_i <= tone_ctr + TONE_TOL_HZ);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ring_d1_q <= 1'b0;
            ring_per_q <= 32'h0;
            ring_edges_q <= 4'h0;
        end
        else
        begin
            ring_d1_q <= ring_i;
            if (ring_i && !ring_d1_q)
            begin
                ring_per_q <= 32'h0;
                if (ring_per_q >= RING_MIN_CYC && ring_per_q <= RING_MAX_CYC)
                    ring_edges_q <= ring_ok ? ring_edges_q : ring_edges_q + 4'h1;
                else
                    ring_edges_q <= 4'h0;
            end
            else if (ring_per_q > RING_MAX_CYC)
                ring_edges_q <= 4'h0;
            else
                ring_per_q <= ring_per_q + 32'h1;
        end
    end
    assign ring_ok = (ring_edges_q == RING_EDGES);

    // ----------------------------------------
    // escape detector: three guard-free plus chars
    // ----------------------------------------
    logic [1:0] esc_cnt_q;
    logic esc_hit;
    assign esc_hit = dte_valid_i && dte_char_i == esc_char && esc_char <= ESC_LIMIT
        && esc_cnt_q == 2'h2 && st_q == CST_DATA;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || st_q != CST_DATA || esc_char > ESC_LIMIT)
            esc_cnt_q <= 2'h0;
        else if (dte_valid_i)
            esc_cnt_q <= (dte_char_i == esc_char && esc_cnt_q != 2'h2) ?
                esc_cnt_q + 2'h1 : 2'h0;
    end

    // ----------------------------------------
    // call state machine and timers
    // ----------------------------------------
    logic in_data;
    logic act;
    logic drop_car;
    logic drop_idle;
    logic drop_clr;
    logic drop_ret;
    logic abort;
    logic [7:0] idle_lim;

    assign in_data = (st_q == CST_DATA);
    assign idle_lim = times_q[23:16];
    assign act = dte_valid_i || line_data_i;
    assign abort = st_q == CST_DIAL && tick && sec_q + 8'h1 >= times_q[7:0];
    assign drop_car = in_data && mod_i == MOD_LOW && !carrier_i && tick
        && cd_q + 8'h1 > times_q[15:8];
    assign drop_idle = in_data && idle_lim != 8'h0 && tick && !act
        && idle_q >= idle_lim;
    assign drop_clr = in_data && mod_i != MOD_LOW && !ec_i && cleardown_i;
    assign drop_ret = st_q == CST_RETR && tick && sec_q >= RETRAIN_S;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_q <= CST_IDLE;
        else
            case (st_q)
                CST_IDLE:
                    if (dial_done_i)
                        st_q <= CST_DIAL;
                    else if (answer_i)
                        st_q <= CST_BILL;
                CST_DIAL:
                    if (tone_ok)
                        st_q <= CST_HAND;
                    else if (abort)
                        st_q <= CST_IDLE;
                CST_BILL:
                    if (tick && sec_q + 8'h1 >= (ctrl_q[C_FAX] ? BILL_FAX_S : BILL_DATA_S))
                        st_q <= CST_HAND;
                CST_HAND:
                    if (handshake_done_i)
                        st_q <= CST_DATA;
                CST_DATA:
                    if (drop_car || drop_idle || drop_clr)
                        st_q <= CST_IDLE;
                    else if (esc_hit)
                        st_q <= CST_CMD;
                    else if (ctrl_q[C_RETRAIN] && !quality_ok_i)
                        st_q <= CST_RETR;
                CST_RETR:
                    if (quality_ok_i)
                        st_q <= CST_DATA;
                    else if (drop_ret)
                        st_q <= CST_IDLE;
                CST_CMD:
                    if (!handshake_done_i)
                        st_q <= CST_IDLE;
                default: st_q <= CST_IDLE;
            endcase
    end

    // one seconds counter serves the dial, billing and retrain phases
    always_ff @(posedge clk_i)
    begin
        if (rst_i || st_q == CST_IDLE || st_q == CST_DATA || st_q == CST_HAND)
            sec_q <= 8'h0;
        else if (tick && sec_q != 8'hff)
            sec_q <= sec_q + 8'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !in_data || carrier_i)
            cd_q <= 8'h0;
        else if (tick && cd_q != 8'hff)
            cd_q <= cd_q + 8'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !in_data || act)
            idle_q <= 8'h0;
        else if (tick && idle_q != 8'hff)
            idle_q <= idle_q + 8'h1;
    end

    assign ev[I_ABORT] = abort && !tone_ok;
    assign ev[I_CARRIER] = drop_car;
    assign ev[I_RETRAIN] = drop_ret && !quality_ok_i;
    assign ev[I_IDLE] = drop_idle;
    assign ev[I_CLEAR] = drop_clr;
    assign ev[I_BREAK] = in_data && (dte_break_i || line_break_i);
    assign ev[I_ESCAPE] = esc_hit;
    assign ev[I_RING] = ring_i && !ring_d1_q && ring_ok;

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic v92;
    assign v92 = in_data && mod_i == MOD_V92 && v92_server_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            off_hook_o <= 1'b0;
            data_mode_o <= 1'b0;
            data_block_o <= 1'b0;
            retrain_o <= 1'b0;
            cts_o <= 1'b1;
            xoff_req_o <= 1'b0;
            rate_step_o <= 2'h0;
            up_max_o <= UP_STD_MAX;
            feat_en_o <= 3'h0;
            break_act_o <= 1'b0;
        end
        else
        begin
            off_hook_o <= st_q != CST_IDLE;
            data_mode_o <= in_data;
            data_block_o <= st_q == CST_BILL;
            retrain_o <= st_q == CST_RETR;
            // throttling only needed when the line is the slower side
            cts_o <= !(in_data && rate_slower_i && ctrl_q[C_RTS]);
            xoff_req_o <= in_data && rate_slower_i && ctrl_q[C_SWFC];
            rate_step_o <= (in_data && mod_i != MOD_LOW && ctrl_q[C_SHIFT]) ?
                {rate_dn_i, rate_up_i} : 2'h0;
            up_max_o <= (v92 && ctrl_q[C_PCM] && srv_feat_i[2]) ? UP_PCM_MAX : UP_STD_MAX;
            feat_en_o <= v92 ? (srv_feat_i & {ctrl_q[C_PCM], ctrl_q[C_QC], ctrl_q[C_HOLD]})
                : 3'h0;
            break_act_o <= ev[I_BREAK] && ctrl_q[C_BRK];
        end
    end
endmodule

//--- verif/cst_top_asserts.sv
/*
 checker for the call supervision block: bus handshake, reset levels, gating and timer bounds.
 assumes it is bound into cst_top and sees only its ports on the single clock domain.
 */
`timescale 1ns/100ps
module cst_top_chk
    import cst_pkg::*;
#(
    parameter int unsigned TICK_LEN = 20
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic int_o,
    // call inputs
    input wire logic handshake_done_i,
    input wire logic [1:0] mod_i,
    input wire logic v92_server_i,
    input wire logic [2:0] srv_feat_i,
    input wire logic dte_break_i,
    input wire logic line_break_i,
    // call outputs
    input wire logic off_hook_o,
    input wire logic data_mode_o,
    input wire logic data_block_o,
    input wire logic retrain_o,
    input wire logic cts_o,
    input wire logic [1:0] rate_step_o,
    input wire logic [9:0] up_max_o,
    input wire logic [2:0] feat_en_o,
    input wire logic break_act_o
);
    // ----------------------------------------
    // retrain length counter
    // ----------------------------------------
    // a counter, since thirty seconds of ticks is far beyond any repetition
    localparam int unsigned RETR_MAX = 31 * TICK_LEN + 4;
    logic [31:0] retr_cnt_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !retrain_o)
            retr_cnt_q <= 32'h0;
        else
            retr_cnt_q <= retr_cnt_q + 32'h1;
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held beyond one cycle");
    a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered in the next cycle");
    a_upstream_caps: assert property (up_max_o == UP_STD_MAX || up_max_o == UP_PCM_MAX)
        else $error("upstream cap outside the two allowed values");
    a_reset_levels: assert property ($fell(rst_i) |-> cts_o && !off_hook_o
        && !data_mode_o && up_max_o == UP_STD_MAX && feat_en_o == 3'h0)
        else $error("outputs not at reset levels after reset");
    a_quiet_excl: assert property (data_block_o |-> !data_mode_o)
        else $error("data mode during the quiet period");
    a_data_entry: assert property ($rose(data_mode_o) |-> handshake_done_i)
        else $error("data mode entered without finished handshake");
    a_feature_gate: assert property (feat_en_o != 3'h0 |-> mod_i == MOD_V92 && v92_server_i
        && (feat_en_o & ~srv_feat_i) == 3'h0)
        else $error("v92 feature enabled without a supporting server");
    a_break_cause: assert property (break_act_o |-> $past(dte_break_i)
        || $past(line_break_i) || $past(dte_break_i, 2) || $past(line_break_i, 2))
        else $error("break action without a break");
    a_retrain_bound: assert property (retr_cnt_q <= RETR_MAX)
        else $error("retrain lasted beyond its limit");
    a_step_class: assert property (rate_step_o != 2'h0 |-> mod_i != MOD_LOW)
        else $error("rate step in a low speed modulation");
    c_data_mode: cover property ($rose(data_mode_o));
    c_irq_raised: cover property ($rose(int_o));
    c_retrain: cover property ($rose(retrain_o));
endmodule
bind cst_top cst_top_chk #(.TICK_LEN(TICK_LEN)) u_cst_top_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .ack_o, .int_o, .handshake_done_i, .mod_i, .v92_server_i, .srv_feat_i, .dte_break_i,
    .line_break_i, .off_hook_o, .data_mode_o, .data_block_o, .retrain_o, .cts_o, .rate_step_o,
    .up_max_o, .feat_en_o, .break_act_o);

//--- verif/cst_remote_model.sv
/*
 remote modem model: carrier, handshake completion and line quality.
 assumes the bench raises link after the quiet period and steers fades and noise.
 */
`timescale 1ns/100ps
module cst_remote_model
#(
    parameter int HS_DLY = 6
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench controls
    input wire logic link_i,
    input wire logic fade_i,
    input wire logic noisy_i,
    // line status
    output logic carrier_o,
    output logic hs_done_o,
    output logic quality_o
);
    logic [7:0] hs_cnt_q;
    // handshake takes a while after the link comes up, never at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !link_i)
            hs_cnt_q <= 8'h0;
        else if (hs_cnt_q != 8'hff)
            hs_cnt_q <= hs_cnt_q + 8'h1;
    end
    assign hs_done_o = int'(hs_cnt_q) > HS_DLY;
    assign carrier_o = link_i && !fade_i;
    assign quality_o = link_i && !noisy_i;
endmodule

//--- verif/tb_top.sv
/*
 bench for the call supervision block: wishbone register tasks and call scenarios.
 assumes a shortened tick of 20 cycles and the remote modem model on the line side.
 */
`timescale 1ns/100ps
module tb_top;
    import cst_pkg::*;
    localparam int T = 20;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h0, dchar = 8'h0;
    logic [31:0] wdat = 32'h0, rd_q, dat_o;
    logic dial = 1'b0, ans = 1'b0, tone_v = 1'b0, cdown = 1'b0, lbrk = 1'b0, ldata = 1'b0;
    logic v92 = 1'b0, ec = 1'b0, dval = 1'b0, dbrk = 1'b0, slow = 1'b0;
    logic link = 1'b0, fade = 1'b0, noisy = 1'b0, carrier, hs_done, qual;
    logic [11:0] tone_hz = 12'h0;
    logic [1:0] mod = 2'h0, rate_step_o;
    logic [2:0] feat = 3'h0, feat_en_o;
    logic [9:0] up_max_o;
    logic ack_o, int_o, off_hook_o, data_mode_o, data_block_o, retrain_o, cts_o;
    logic xoff_req_o, break_act_o;
    int mismatches = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    cst_top #(.TICK_LEN(T)) u_cst_top (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o, .ack_o, .int_o, .dial_done_i(dial),
        .answer_i(ans), .tone_valid_i(tone_v), .tone_hz_i(tone_hz), .ring_i(1'b0),
        .handshake_done_i(hs_done), .mod_i(mod), .ec_i(ec), .carrier_i(carrier),
        .quality_ok_i(qual), .cleardown_i(cdown), .line_break_i(lbrk), .line_data_i(ldata),
        .v92_server_i(v92), .srv_feat_i(feat), .rate_up_i(1'b0), .rate_dn_i(1'b0),
        .dte_valid_i(dval), .dte_char_i(dchar), .dte_break_i(dbrk), .rts_i(1'b1),
        .rate_slower_i(slow), .off_hook_o, .data_mode_o, .data_block_o, .retrain_o, .cts_o,
        .xoff_req_o, .rate_step_o, .up_max_o, .feat_en_o, .break_act_o);
    cst_remote_model u_cst_remote_model (.clk_i, .rst_i, .link_i(link), .fade_i(fade),
        .noisy_i(noisy), .carrier_o(carrier), .hs_done_o(hs_done), .quality_o(qual));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // waits on ack with no cycle count assumed; the watchdog cuts a hang
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd_q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task rst(input int n);
        rst_i <= 1'b1;
        link <= 1'b0;
        fade <= 1'b0;
        noisy <= 1'b0;
        tone_v <= 1'b0;
        slow <= 1'b0;
        wt(n);
        rst_i <= 1'b0;
    endtask
    task fin(input string s);
        $display("test %s done", s);
    endtask
    task connect(input logic [31:0] ctrl, input logic [31:0] tm, input logic fax,
        input logic [1:0] m);
        rst(2);
        mod <= m;
        wb(1'b1, A_TIMES, tm);
        wb(1'b1, A_CTRL, ctrl | (32'(fax) << C_FAX));
        ans <= 1'b1;
        wt(1);
        ans <= 1'b0;
        wt((fax ? 4 : 2) * T);
        chk("quiet period", data_block_o, 1'h1);
        wt(8);
        chk("quiet end", data_block_o, 1'h0);
        chk("no data before handshake", data_mode_o, 1'h0);
        link <= 1'b1;
        wt(12);
        chk("data entry", data_mode_o, 1'h1);
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        wt(12);
        rst_i <= 1'b0;
        wb(1'b0, A_CTRL, 32'h0);
        chk("ctrl reset", rd_q, CTRL_RST);
        wb(1'b0, A_TIMES, 32'h0);
        chk("times reset", rd_q, TIMES_RST);
        wb(1'b0, A_STATUS, 32'h0);
        chk("state reset", rd_q[2:0], CST_IDLE);
        chk("upstream reset", up_max_o, UP_STD_MAX);
        wb(1'b1, 8'h1c, 32'hffff_ffff);
        wb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", rd_q, 32'h0);
        fin("registers");
        for (int i = 0; i < 4; i++)
        begin
            rst(2);
            wb(1'b1, A_TIMES, 32'h0000_0102);
            wb(1'b1, A_CTRL, 32'(i / 2) << C_BELL);
            tone_hz <= (i == 0) ? TONE_ITU_HZ - TONE_TOL_HZ : (i == 1) ?
                TONE_ITU_HZ + TONE_TOL_HZ + 12'h1 : (i == 2) ?
                TONE_BELL_HZ + TONE_TOL_HZ : TONE_ITU_HZ;
            tone_v <= 1'b1;
            dial <= 1'b1;
            wt(1);
            dial <= 1'b0;
            wt(3 * T + 6);
            wb(1'b0, A_IRQ, 32'h0);
            chk("dial abort", rd_q[0], 32'(i % 2));
        end
        wb(1'b1, A_MASK, 32'h0);
        wt(1);
        chk("irq raised", int_o, 1'h1);
        wb(1'b1, A_MASK, 32'h1);
        wt(1);
        chk("irq masked", int_o, 1'h0);
        wb(1'b1, A_IRQ, 32'h1);
        wb(1'b0, A_IRQ, 32'h0);
        chk("irq cleared", rd_q[0], 1'h0);
        fin("dial");
        for (int i = 0; i < 2; i++)
        begin
            connect(32'h0, 32'h0000_0100, 1'(i), 2'(i));
            fade <= 1'b1;
            wt(T);
            chk("carrier hold", data_mode_o, 1'h1);
            wt(2 * T + 6);
            chk("carrier drop", data_mode_o, 32'(i));
            wb(1'b0, A_IRQ, 32'h0);
            chk("carrier irq", rd_q[1], 32'(1 - i));
        end
        fin("answer and carrier");
        for (int i = 0; i < 2; i++)
        begin
            dchar <= i ? 8'h80 : ESC_PLUS;
            connect({8'h0, i ? 8'h80 : ESC_PLUS, 16'h0}, 32'h0, 1'b0, MOD_V32);
            repeat (3)
            begin
                dval <= 1'b1;
                wt(1);
                dval <= 1'b0;
                wt(2);
            end
            wt(3);
            wb(1'b0, A_STATUS, 32'h0);
            chk("escape", rd_q[2:0], i ? CST_DATA : CST_CMD);
        end
        fin("escape");
        for (int i = 0; i < 2; i++)
        begin
            dchar <= 8'h41;
            connect(32'h0, i ? 32'h0 : 32'h0003_0000, 1'b0, MOD_V32);
            repeat (2)
            begin
                ldata <= 1'b1;
                wt(1);
                ldata <= 1'b0;
                wt(30);
                dval <= 1'b1;
                wt(1);
                dval <= 1'b0;
                wt(30);
            end
            chk("idle kept", data_mode_o, 1'h1);
            wt(4 * T + 6);
            chk("idle drop", data_mode_o, 32'(i));
        end
        fin("inactivity");
        for (int i = 0; i < 2; i++)
        begin
            ec <= 1'(i);
            connect(32'h200, 32'h0, 1'b0, MOD_V32);
            lbrk <= 1'b1;
            wt(1);
            lbrk <= 1'b0;
            cdown <= 1'b1;
            wt(1);
            chk("break action", break_act_o, 1'h1);
            cdown <= 1'b0;
            wt(4);
            chk("cleardown", data_mode_o, 32'(i));
            wb(1'b0, A_IRQ, 32'h0);
            chk("cleardown irq", rd_q[4], 32'(1 - i));
            chk("break seen", rd_q[5], 1'h1);
        end
        fin("cleardown and break");
        for (int i = 0; i < 2; i++)
        begin
            v92 <= 1'b1;
            feat <= 3'h5;
            connect(32'h7c, 32'h0, 1'b0, i ? MOD_V90 : MOD_V92);
            wt(4);
            chk("features", feat_en_o, i ? 3'h0 : 3'h5);
            chk("upstream cap", up_max_o, i ? UP_STD_MAX : UP_PCM_MAX);
            slow <= 1'b1;
            wt(4);
            chk("terminal throttled", xoff_req_o, 1'h1);
            chk("flow stopped", cts_o, 1'h0);
        end
        fin("v92 and flow");
        connect(32'h1, 32'h0, 1'b0, MOD_V32);
        noisy <= 1'b1;
        wt(6);
        chk("retrain on", retrain_o, 1'h1);
        wt(27 * T);
        chk("retrain kept", retrain_o, 1'h1);
        wt(4 * T);
        chk("retrain drop", off_hook_o, 1'h0);
        wb(1'b0, A_IRQ, 32'h0);
        chk("retrain irq", rd_q[2], 1'h1);
        fin("retrain");
        print_verdict();
    end
    initial
    begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
